/* hw/frb_defs.svh */
/*
 Register offsets, bit positions, reset values and counts of the FIFO readout
 and feature register bank. Assumes inclusion by bare name from design files.
*/
`ifndef FRB_DEFS_SVH
`define FRB_DEFS_SVH
`define FRB_ADDR_DATA_FIRST 8'h02
`define FRB_ADDR_DATA_LAST 8'h07
`define FRB_ADDR_STAT1 8'h08
`define FRB_ADDR_STAT2 8'h09
`define FRB_ADDR_COUNT 8'h0a
`define FRB_ADDR_CFG1 8'h0d
`define FRB_ADDR_CFG2 8'h0e
`define FRB_CFG1_RESET 8'h00
`define FRB_CFG2_RESET 8'h00
`define FRB_COUNT_RESET 6'h00
`define FRB_BIT_HOLD 3
`define FRB_BIT_REARM 4
`define FRB_BIT_THREE 5
`define FRB_BIT_I2C 6
`define FRB_BIT_SPI 7
`define FRB_BIT_WRAP 0
`define FRB_BIT_BURST 1
`define FRB_BIT_CLRWR 4
`define FRB_BIT_STREAM 5
`define FRB_FIFO_DEPTH 6'h20
`define FRB_MAX_GROUPS 6'h20
`endif

/* hw/frb_pkg.sv */
/*
 Types shared by the register bank and its sample memory.
 Assumes nothing of its surroundings.
*/
package frb_pkg;
	typedef struct packed {
		logic [15:0] z;
		logic [15:0] y;
		logic [15:0] x;
	} frb_sample_t;
	typedef struct packed {
		logic start;
		logic write;
		logic spi;
		logic [7:0] addr;
	} frb_start_t;
	typedef enum logic [1:0] {
		FRB_IDLE = 2'b00,
		FRB_READ = 2'b01,
		FRB_WRITE = 2'b10
	} frb_state_t;
endpackage

/* hw/frb_sample_mem.sv */
/*
 Thirty-two entry sample store with one write port and a registered read.
 Assumes the caller allows one cycle after a pointer change for read data.
*/
`timescale 1ns/1ns
`default_nettype none
module frb_sample_mem (
	// Clock
	input wire logic clk,
	// Write side
	input wire logic wr_en,
	input wire logic [4:0] wr_addr,
	input wire frb_pkg::frb_sample_t wr_data,
	// Read side
	input wire logic [4:0] rd_addr,
	output frb_pkg::frb_sample_t rd_data
);
	frb_pkg::frb_sample_t mem [0:31];

	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk) begin
		rd_data <= mem[rd_addr];
	end
endmodule
`default_nettype wire

/* hw/frb_regs.sv */
/*
 FIFO readout and feature register bank: sample count, interface select,
 sniff detector arming, burst address wrap and FIFO burst pops, with a
 two-entry buffer in the read byte path. Assumes link engines that deliver
 decoded accesses synchronous to clk and a pipeline giving sample pulses.
*/
`timescale 1ns/1ns
`default_nettype none
`include "frb_defs.svh"
// Contract
// - Count of held samples, zero to thirty-two
// - Count follows pushes and pops immediately
// - No result update while both selects zero
// - Both selects zero keep power-up link
// - Hold bit stops FIFO capture on detect irq
// - Detector ignores events while irq pending
// - Rearm off: only leaving mode rearms
// - Rearm on: clearing irq rearms detector
// - Wire-count bit picks four or three wire
// - Two-wire select blocks serial accesses
// - Serial select blocks two-wire accesses
// - Wrap zero: after 0x07 go 0x02
// - Wrap one: after 0x09 go 0x02
// - Wrap and burst same on every link
// - Burst off: one group per transaction
// - Burst on: up to 32 groups popped
// - Stream drops oldest, else full refuses
// - Irq clear by read or write per link
module frb_regs (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Power-up link strap
	input wire logic powerup_link_spi,
	// Accesses from the link engines
	input wire frb_pkg::frb_start_t acc,
	input wire logic acc_wr_valid,
	input wire logic [7:0] acc_wr_data,
	input wire logic acc_stop,
	// Read byte stream
	output logic rd_valid,
	output logic [7:0] rd_data,
	input wire logic rd_ready,
	// Sampling pipeline
	input wire logic smp_valid,
	input wire frb_pkg::frb_sample_t smp_data,
	input wire logic fifo_enable,
	input wire logic fifo_stream,
	input wire logic sniff_event,
	input wire logic combined_detect_sample_mode,
	input wire logic [7:0] status1_in,
	input wire logic [6:0] int_other_in,
	// Status outputs
	output logic combined_detect_irq,
	output logic link_spi_active,
	output logic three_wire_select,
	output logic [5:0] fifo_count
);
	frb_pkg::frb_state_t state_reg;
	frb_pkg::frb_sample_t res_reg;
	frb_pkg::frb_sample_t mem_q;
	frb_pkg::frb_sample_t src;
	logic [7:0] cfg1_reg, cfg2_reg, addr_reg, addr_next, rbyte, wrap_end;
	logic [5:0] count_reg, groups_reg;
	logic [4:0] wr_ptr_reg, rd_ptr_reg;
	logic strap_taken_reg, powerup_spi_reg, link_spi_next;
	logic irq_reg, armed_reg, stale_reg, det_set, clr;
	logic v0_reg, v1_reg, gen, bpop, pop_rd, push_ok, push, pop, full, sel_any;
	logic [7:0] d0_reg, d1_reg;
	logic acc_ok, wr_hit;

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	// Catch the power-up link strap once after reset release.
	always_ff @(posedge clk) begin
		if (reset) begin
			strap_taken_reg <= 1'b0;
			powerup_spi_reg <= 1'b0;
		end else if (!strap_taken_reg) begin
			strap_taken_reg <= 1'b1;
			powerup_spi_reg <= powerup_link_spi;
		end
	end

	assign sel_any = cfg1_reg[`FRB_BIT_SPI] | cfg1_reg[`FRB_BIT_I2C];
	// Serial select takes priority if the host sets both.
	assign link_spi_next = cfg1_reg[`FRB_BIT_SPI] ? 1'b1 :
		cfg1_reg[`FRB_BIT_I2C] ? 1'b0 : powerup_spi_reg;

	always_ff @(posedge clk) begin
		if (reset) begin
			link_spi_active <= 1'b0;
			three_wire_select <= 1'b0;
		end else begin
			link_spi_active <= link_spi_next;
			three_wire_select <= link_spi_next & cfg1_reg[`FRB_BIT_THREE];
		end
	end

	// Accesses arriving on the deselected link are ignored.
	assign acc_ok = acc.start & (acc.spi == link_spi_active);

	// Address sequencing does not depend on the link in use.
	assign wrap_end = cfg2_reg[`FRB_BIT_WRAP] ? `FRB_ADDR_STAT2 : `FRB_ADDR_DATA_LAST;
	assign addr_next = (addr_reg == wrap_end) ? `FRB_ADDR_DATA_FIRST :
		addr_reg + 8'h01;

	always_ff @(posedge clk) begin
		if (reset) begin
			state_reg <= frb_pkg::FRB_IDLE;
		end else if (acc_ok) begin
			state_reg <= acc.write ? frb_pkg::FRB_WRITE : frb_pkg::FRB_READ;
		end else if (acc_stop) begin
			state_reg <= frb_pkg::FRB_IDLE;
		end
	end

	assign wr_hit = (state_reg == frb_pkg::FRB_WRITE) & acc_wr_valid;
	assign gen = (state_reg == frb_pkg::FRB_READ) & !v1_reg & !stale_reg & !acc_ok;

	always_ff @(posedge clk) begin
		if (reset) begin
			addr_reg <= 8'h00;
		end else if (acc_ok) begin
			addr_reg <= acc.addr;
		end else if (gen || wr_hit) begin
			addr_reg <= addr_next;
		end
	end

	// Configuration registers written by the host.
	always_ff @(posedge clk) begin
		if (reset) begin
			cfg1_reg <= `FRB_CFG1_RESET;
			cfg2_reg <= `FRB_CFG2_RESET;
		end else if (wr_hit && addr_reg == `FRB_ADDR_CFG1) begin
			cfg1_reg <= acc_wr_data;
		end else if (wr_hit && addr_reg == `FRB_ADDR_CFG2) begin
			cfg2_reg <= acc_wr_data;
		end
	end

	// Clear by read on two-wire unless write-clear chosen; serial clears by write.
	assign clr = (gen & addr_reg == `FRB_ADDR_STAT2 & !link_spi_active &
		!cfg2_reg[`FRB_BIT_CLRWR]) |
		(wr_hit & addr_reg == `FRB_ADDR_STAT2 & (link_spi_active | cfg2_reg[`FRB_BIT_CLRWR]));

	assign det_set = sniff_event & armed_reg & combined_detect_sample_mode;

	// A new detection wins over a clear in the same cycle.
	always_ff @(posedge clk) begin
		if (reset) begin
			irq_reg <= 1'b0;
		end else if (det_set) begin
			irq_reg <= 1'b1;
		end else if (clr) begin
			irq_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			armed_reg <= 1'b1;
		end else if (!combined_detect_sample_mode) begin
			armed_reg <= 1'b1;
		end else if (det_set) begin
			armed_reg <= 1'b0;
		end else if (clr && cfg1_reg[`FRB_BIT_REARM]) begin
			armed_reg <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			combined_detect_irq <= 1'b0;
		end else begin
			combined_detect_irq <= irq_reg;
		end
	end

	// Result registers load only once a link has been selected.
	always_ff @(posedge clk) begin
		if (reset) begin
			res_reg <= '0;
		end else if (smp_valid && sel_any) begin
			res_reg <= smp_data;
		end
	end

	// FIFO push, pop and occupancy.
	assign full = (count_reg == `FRB_FIFO_DEPTH);
	assign push_ok = smp_valid & sel_any & fifo_enable &
		!(irq_reg & cfg1_reg[`FRB_BIT_HOLD]);
	assign pop_rd = gen & addr_reg == `FRB_ADDR_DATA_LAST & fifo_enable &
		(count_reg != `FRB_COUNT_RESET) &
		(cfg2_reg[`FRB_BIT_BURST] ? (groups_reg < `FRB_MAX_GROUPS) :
		(groups_reg == 6'h00));
	assign push = push_ok & (!full | fifo_stream | pop_rd);
	assign pop = pop_rd | (push & full & !pop_rd);

	always_ff @(posedge clk) begin
		if (reset) begin
			count_reg <= `FRB_COUNT_RESET;
			wr_ptr_reg <= 5'h00;
			rd_ptr_reg <= 5'h00;
		end else begin
			count_reg <= count_reg + {5'h00, push} - {5'h00, pop};
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 5'h01;
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + 5'h01;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			fifo_count <= `FRB_COUNT_RESET;
		end else begin
			fifo_count <= count_reg + {5'h00, push} - {5'h00, pop};
		end
	end

	// Memory output lags a pointer move by one cycle.
	always_ff @(posedge clk) begin
		if (reset) begin
			stale_reg <= 1'b0;
		end else begin
			stale_reg <= push | pop;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			groups_reg <= 6'h00;
		end else if (acc_ok) begin
			groups_reg <= 6'h00;
		end else if (pop_rd) begin
			groups_reg <= groups_reg + 6'h01;
		end
	end

	frb_sample_mem u_mem (
		.clk(clk),
		.wr_en(push),
		.wr_addr(wr_ptr_reg),
		.wr_data(smp_data),
		.rd_addr(rd_ptr_reg),
		.rd_data(mem_q)
	);

	assign src = fifo_enable ? mem_q : res_reg;

	always_comb begin
		rbyte = 8'h00;
		case (addr_reg)
			8'h02: rbyte = src.x[7:0];
			8'h03: rbyte = src.x[15:8];
			8'h04: rbyte = src.y[7:0];
			8'h05: rbyte = src.y[15:8];
			8'h06: rbyte = src.z[7:0];
			8'h07: rbyte = src.z[15:8];
			`FRB_ADDR_STAT1: rbyte = status1_in;
			`FRB_ADDR_STAT2: rbyte = {irq_reg, int_other_in};
			`FRB_ADDR_COUNT: rbyte = {2'b00, count_reg};
			`FRB_ADDR_CFG1: rbyte = cfg1_reg;
			`FRB_ADDR_CFG2: rbyte = cfg2_reg;
			default: rbyte = 8'h00;
		endcase
	end

	// Two-entry read buffer; generation stalls while the second slot is full.
	assign bpop = rd_ready & v0_reg;

	always_ff @(posedge clk) begin
		if (reset || acc_ok) begin
			v0_reg <= 1'b0;
			v1_reg <= 1'b0;
			d0_reg <= 8'h00;
			d1_reg <= 8'h00;
		end else begin
			case ({gen, bpop})
				2'b01: begin
					if (v1_reg) begin
						d0_reg <= d1_reg;
						v1_reg <= 1'b0;
					end else begin
						v0_reg <= 1'b0;
					end
				end
				2'b10: begin
					if (!v0_reg) begin
						d0_reg <= rbyte;
						v0_reg <= 1'b1;
					end else begin
						d1_reg <= rbyte;
						v1_reg <= 1'b1;
					end
				end
				2'b11: begin
					d0_reg <= rbyte;
				end
				default: begin
					v0_reg <= v0_reg;
				end
			endcase
		end
	end

	assign rd_valid = v0_reg;
	assign rd_data = d0_reg;

	property p_count_max;
		count_reg <= `FRB_FIFO_DEPTH;
	endproperty
	a_count_max: assert property (p_count_max) else $error("count above 32");
	property p_count_out;
		push && !pop |=> fifo_count == $past(fifo_count) + 6'h01;
	endproperty
	a_count_out: assert property (p_count_out) else $error("count not tracking");
	property p_no_result;
		!sel_any |=> $stable(res_reg);
	endproperty
	a_no_result: assert property (p_no_result) else $error("result updated");
	property p_powerup_link;
		strap_taken_reg && !sel_any |=> link_spi_active == $past(powerup_spi_reg);
	endproperty
	a_powerup_link: assert property (p_powerup_link) else $error("link lost");
	property p_hold;
		irq_reg && cfg1_reg[`FRB_BIT_HOLD] |-> !push;
	endproperty
	a_hold: assert property (p_hold) else $error("capture during hold");
	property p_ignore;
		irq_reg && combined_detect_sample_mode && $past(combined_detect_sample_mode)
			&& $past(irq_reg) |-> !det_set;
	endproperty
	a_ignore: assert property (p_ignore) else $error("event taken while pending");
	property p_rearm_on;
		clr && cfg1_reg[`FRB_BIT_REARM] && !det_set |=> armed_reg;
	endproperty
	a_rearm_on: assert property (p_rearm_on) else $error("not rearmed");
	property p_rearm_off;
		!armed_reg && combined_detect_sample_mode && !cfg1_reg[`FRB_BIT_REARM]
			##1 combined_detect_sample_mode |-> !armed_reg;
	endproperty
	a_rearm_off: assert property (p_rearm_off) else $error("rearmed by clear");
	property p_wrap;
		gen && !acc_stop && addr_reg == wrap_end |=> addr_reg == `FRB_ADDR_DATA_FIRST;
	endproperty
	a_wrap: assert property (p_wrap) else $error("bad wrap");
	property p_blocked;
		acc.start && acc.spi != link_spi_active && !acc_stop |=> $stable(state_reg);
	endproperty
	a_blocked: assert property (p_blocked) else $error("blocked link accepted");
	property p_burst_off;
		!cfg2_reg[`FRB_BIT_BURST] && groups_reg != 6'h00 |-> !pop_rd;
	endproperty
	a_burst_off: assert property (p_burst_off) else $error("second group popped");
	property p_full_refuse;
		full && !fifo_stream && !pop_rd |-> !push;
	endproperty
	a_full_refuse: assert property (p_full_refuse) else $error("push when full");
endmodule
`default_nettype wire

/* tb/frb_host_model.sv */
/*
 Host model: opens transactions, writes bytes and takes read bytes with a
 stalling ready. Assumes the bank's clk and the access contract timing.
*/
`timescale 1ns/1ns
`default_nettype none
module frb_host_model (
	// Clock
	input wire logic clk,
	// Access side
	output frb_pkg::frb_start_t acc,
	output logic acc_wr_valid,
	output logic [7:0] acc_wr_data,
	output logic acc_stop,
	// Read bytes
	input wire logic rd_valid,
	output logic rd_ready
);
	initial begin
		acc = '0;
		acc_wr_valid = 1'b0;
		acc_wr_data = 8'h00;
		acc_stop = 1'b0;
		rd_ready = 1'b0;
	end
	task automatic open_txn(input logic w, input logic s, input logic [7:0] a);
		@(negedge clk);
		acc = {1'b1, w, s, a};
		@(negedge clk);
		acc.start = 1'b0;
		acc.addr = ~a;
	endtask
	task automatic close_txn();
		acc_stop = 1'b1;
		@(negedge clk);
		acc_stop = 1'b0;
	endtask
	task automatic wr(input logic s, input logic [7:0] a, input logic [7:0] d);
		logic [7:0] v;
		v = d;
		if (a == 8'h0d) begin
			v[2:0] = 3'h0;
			v[6] = v[6] & ~v[7];
		end
		open_txn(1'b1, s, a);
		acc_wr_valid = 1'b1;
		acc_wr_data = v;
		@(negedge clk);
		acc_wr_valid = 1'b0;
		acc_wr_data = ~v;
		close_txn();
	endtask
	task automatic rd(input logic s, input logic [7:0] a, input int n);
		int k;
		k = 0;
		open_txn(1'b0, s, a);
		while (k < n) begin
			rd_ready = ($urandom_range(3) != 0);
			@(posedge clk);
			if (rd_valid && rd_ready)
				k++;
			@(negedge clk);
		end
		rd_ready = 1'b0;
		close_txn();
	endtask
endmodule
`default_nettype wire

/* tb/testbench.sv */
/*
 Self-checking bench of the register bank with a host model.
 Assumes the bank, its sample memory and the host model are compiled.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic clk, reset, powerup_link_spi, acc_wr_valid, acc_stop, rd_valid, rd_ready;
	logic smp_valid, fifo_enable, fifo_stream, sniff_event, combined_detect_sample_mode;
	logic combined_detect_irq, link_spi_active, three_wire_select, sel, hold, irq_e;
	logic [7:0] acc_wr_data, rd_data, status1_in;
	logic [6:0] int_other_in;
	logic [5:0] fifo_count;
	frb_pkg::frb_start_t acc;
	frb_pkg::frb_sample_t smp_data, lst;
	frb_pkg::frb_sample_t fq[$];
	logic [7:0] exp_q[$];
	int err_count, checked, cyc;
	frb_regs uut (.clk, .reset, .powerup_link_spi, .acc, .acc_wr_valid, .acc_wr_data,
		.acc_stop, .rd_valid, .rd_data, .rd_ready, .smp_valid, .smp_data, .fifo_enable,
		.fifo_stream, .sniff_event, .combined_detect_sample_mode, .status1_in,
		.int_other_in, .combined_detect_irq, .link_spi_active, .three_wire_select,
		.fifo_count);
	frb_host_model u_host (.clk, .acc, .acc_wr_valid, .acc_wr_data, .acc_stop,
		.rd_valid, .rd_ready);
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic test_done();
		if (err_count == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc > 30000) begin
			err_count++;
			test_done();
		end
	end
	always @(posedge clk)
		if (rd_valid && rd_ready)
			chk("rd_data", exp_q.size() > 0 ? exp_q.pop_front() : ~rd_data, rd_data);
	task automatic push();
		frb_pkg::frb_sample_t s;
		s = {$urandom, 16'($urandom)};
		@(negedge clk);
		smp_valid = 1'b1;
		smp_data = s;
		@(negedge clk);
		smp_valid = 1'b0;
		smp_data = ~s;
		if (sel) begin
			lst = s;
			if (fifo_enable && !(hold && irq_e) && (fq.size() < 32 || fifo_stream)) begin
				if (fq.size() == 32)
					fq.delete(0);
				fq.push_back(s);
			end
		end
	endtask
	task automatic exp_grp(input frb_pkg::frb_sample_t s, input int n);
		for (int i = 0; i < n; i++)
			exp_q.push_back(s[i*8 +: 8]);
	endtask
	task automatic sniff();
		@(negedge clk);
		sniff_event = 1'b1;
		@(negedge clk);
		sniff_event = 1'b0;
		repeat (3) @(negedge clk);
	endtask
	initial begin
		void'($urandom(32'hf366));
		{reset, sel, hold, irq_e, fifo_enable} = 5'h11;
		{powerup_link_spi, smp_valid, fifo_stream, sniff_event} = 4'h8;
		combined_detect_sample_mode = 1'b0;
		smp_data = '0;
		status1_in = 8'($urandom);
		int_other_in = 7'($urandom);
		{err_count, checked, cyc} = '0;
		repeat (12) @(negedge clk);
		reset = 1'b0;
		repeat (3) @(negedge clk);
		exp_q = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		u_host.rd(1'b1, 8'h0a, 5);
		chk("link_spi", 8'h01, 8'(link_spi_active));
		push();
		push();
		chk("count", 8'h00, 8'(fifo_count));
		fifo_enable = 1'b0;
		exp_q = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		u_host.rd(1'b1, 8'h02, 6);
		fifo_enable = 1'b1;
		u_host.wr(1'b1, 8'h0d, 8'h47);
		sel = 1'b1;
		repeat (3) push();
		chk("count", 8'h03, 8'(fifo_count));
		exp_q = '{8'h03, 8'h00, 8'h00, 8'h40};
		u_host.rd(1'b0, 8'h0a, 4);
		exp_grp(fq[0], 6);
		exp_grp(fq[1], 2);
		u_host.rd(1'b0, 8'h02, 8);
		fq.delete(0);
		chk("count", 8'h02, 8'(fifo_count));
		u_host.wr(1'b0, 8'h0e, 8'h02);
		exp_grp(fq[0], 6);
		exp_grp(fq[1], 6);
		u_host.rd(1'b0, 8'h02, 12);
		fq.delete();
		chk("count", 8'h00, 8'(fifo_count));
		u_host.wr(1'b1, 8'h0e, 8'h01);
		exp_q = '{8'h02};
		u_host.rd(1'b0, 8'h0e, 1);
		repeat (33) push();
		chk("count", 8'h20, 8'(fifo_count));
		fifo_stream = 1'b1;
		push();
		exp_grp(fq[0], 6);
		u_host.rd(1'b0, 8'h02, 6);
		fq.delete(0);
		chk("count", 8'h1f, 8'(fifo_count));
		u_host.wr(1'b0, 8'h0e, 8'h01);
		fifo_enable = 1'b0;
		push();
		exp_q = '{lst[47:40], status1_in, {1'b0, int_other_in}, lst[7:0]};
		u_host.rd(1'b0, 8'h07, 4);
		fifo_enable = 1'b1;
		combined_detect_sample_mode = 1'b1;
		sniff();
		irq_e = 1'b1;
		chk("irq", 8'h01, 8'(combined_detect_irq));
		u_host.wr(1'b0, 8'h0d, 8'h48);
		hold = 1'b1;
		push();
		chk("count", 8'(fq.size()), 8'(fifo_count));
		sniff();
		exp_q = '{{1'b1, int_other_in}};
		u_host.rd(1'b0, 8'h09, 1);
		irq_e = 1'b0;
		chk("irq", 8'h00, 8'(combined_detect_irq));
		sniff();
		chk("irq", 8'h00, 8'(combined_detect_irq));
		combined_detect_sample_mode = 1'b0;
		@(negedge clk);
		combined_detect_sample_mode = 1'b1;
		sniff();
		irq_e = 1'b1;
		chk("irq", 8'h01, 8'(combined_detect_irq));
		u_host.wr(1'b0, 8'h0d, 8'h50);
		hold = 1'b0;
		push();
		chk("count", 8'(fq.size()), 8'(fifo_count));
		exp_q = '{{1'b1, int_other_in}};
		u_host.rd(1'b0, 8'h09, 1);
		sniff();
		chk("irq", 8'h01, 8'(combined_detect_irq));
		u_host.wr(1'b0, 8'h0d, 8'ha0);
		repeat (2) @(negedge clk);
		chk("link_spi", 8'h01, 8'(link_spi_active));
		chk("three_wire", 8'h01, 8'(three_wire_select));
		u_host.wr(1'b0, 8'h0e, 8'h00);
		exp_q = '{status1_in, {1'b1, int_other_in}, fq[0][7:0]};
		u_host.rd(1'b1, 8'h08, 3);
		chk("irq", 8'h01, 8'(combined_detect_irq));
		u_host.wr(1'b1, 8'h09, 8'h00);
		chk("irq", 8'h00, 8'(combined_detect_irq));
		u_host.wr(1'b1, 8'h0d, 8'h80);
		repeat (2) @(negedge clk);
		chk("three_wire", 8'h00, 8'(three_wire_select));
		chk("left", 8'h00, 8'(exp_q.size()));
		test_done();
	end
endmodule
`default_nettype wire
